//--- encoder_pulse_divider.sv
// encoder pulse divider: divides quadrature input, optional direction output on B
//
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module encoder_pulse_divider
  import pulse_divider_pkg::*;
(
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // encoder inputs and switch bank (asynchronous pins)
  input  wire logic         i_enc_a,
  input  wire logic         i_enc_b,
  input  wire logic [SW_W-1:0] i_setting_switch_bank_closed,
  // divided outputs
  output logic              o_div_a_p,
  output logic              o_div_a_n,
  output logic              o_div_b_p,
  output logic              o_div_b_n,
  output logic              o_divided_out_a_oc,
  output logic              o_divided_out_a_oc_oe,
  output logic              o_divided_out_b_oc,
  output logic              o_divided_out_b_oc_oe,
  // avalon-mm slave
  input  wire logic [3:0]   i_avs_address,
  input  wire logic         i_avs_read,
  input  wire logic         i_avs_write,
  input  wire logic [31:0]  i_avs_writedata,
  output logic [31:0]       o_avs_readdata,
  output logic              o_avs_waitrequest
);

  // synchronised pins
  logic [SW_W-1:0] sw_closed_s;
  quad_t           enc_s;
  quad_t           enc_q_ff;

  sync2 #(.W(SW_W + 2)) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_d     ({i_setting_switch_bank_closed, i_enc_a, i_enc_b}),
    .o_q     ({sw_closed_s, enc_s})
  );

  // control register: bit0 selects register config over the switches
  logic [31:0] ctrl_ff;
  logic [31:0] nxt_ctrl;
  logic        sw_src_reg;

  // an open switch is logic 1, so the closed-level pin is inverted
  wire logic [SW_W-1:0] sw_logic = ~sw_closed_s;
  wire logic [SW_W-1:0] sw_eff   = sw_src_reg ? ctrl_ff[SW_W:1] : sw_logic;

  cfg_t cfg;
  assign cfg.divisor  = sw_eff[SW_DIV_LSB +: DIV_W];
  assign cfg.dir_mode = sw_eff[SW_MODE];
  assign cfg.clr      = sw_eff[SW_CLR];
  assign sw_src_reg   = ctrl_ff[CTRL_SRC];

  // divisor 0 is outside the operator's range; treated as 1 so the output never freezes
  wire logic [DIV_W-1:0] div_n = (cfg.divisor == '0) ? DIV_MIN : cfg.divisor;

  // quadrature decode: edges of A, direction from phase relation
  wire logic a_rise = enc_s.a & ~enc_q_ff.a;
  wire logic a_fall = ~enc_s.a & enc_q_ff.a;
  wire logic a_edge = a_rise | a_fall;
  wire logic b_edge = enc_s.b ^ enc_q_ff.b;
  // on an A edge, A leads when A and B now differ; on a B edge, A leads when they match
  wire logic b_leads_on_a = ~(enc_s.a ^ enc_s.b);
  wire logic b_leads_on_b = enc_s.a ^ enc_s.b;

  // counter: n input periods = 2n A edges per output period, toggling every n edges
  logic [DIV_W-1:0] cnt_ff;
  logic             div_ff;
  logic             dir_ff;
  wire logic        cnt_wrap = (cnt_ff == div_n - DIV_MIN);
  wire logic [DIV_W-1:0] nxt_cnt = cfg.clr ? (cnt_wrap ? CNT_RST : cnt_ff + DIV_MIN) : CNT_RST;
  wire logic        nxt_div  = cfg.clr ? (div_ff ^ cnt_wrap) : 1'b0;
  wire logic        nxt_dir  = b_edge ? b_leads_on_b : (a_edge ? b_leads_on_a : dir_ff);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      enc_q_ff <= '0;
      cnt_ff   <= CNT_RST;
      div_ff   <= 1'b0;
      dir_ff   <= 1'b0;
    end else begin
      enc_q_ff <= enc_s;
      dir_ff   <= nxt_dir;
      // clear switch at 0 holds the counter at zero
      if (!cfg.clr) begin
        cnt_ff <= CNT_RST;
        div_ff <= 1'b0;
      end else if (a_edge) begin
        cnt_ff <= nxt_cnt;
        div_ff <= nxt_div;
      end
    end
  end

  // output stage, all registered
  wire logic out_b = cfg.dir_mode ? dir_ff : div_ff;
  // divided b follows a quarter-period shift: reuse A edges gated by B level is not worth it,
  // so in pulse mode B repeats the divided signal delayed by one input edge of B
  logic b_div_ff;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      b_div_ff <= 1'b0;
    end else if (!cfg.clr) begin
      b_div_ff <= 1'b0;
    end else if (b_edge) begin
      b_div_ff <= div_ff;
    end
  end
  wire logic out_b_sel = cfg.dir_mode ? dir_ff : b_div_ff;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_div_a_p             <= 1'b0;
      o_div_a_n             <= 1'b1;
      o_div_b_p             <= 1'b0;
      o_div_b_n             <= 1'b1;
      o_divided_out_a_oc    <= 1'b0;
      o_divided_out_a_oc_oe <= 1'b0;
      o_divided_out_b_oc    <= 1'b0;
      o_divided_out_b_oc_oe <= 1'b0;
    end else begin
      o_div_a_p             <= div_ff;
      o_div_a_n             <= ~div_ff;
      o_div_b_p             <= out_b_sel;
      o_div_b_n             <= ~out_b_sel;
      // open collector pulls low for a 0, releases for a 1
      o_divided_out_a_oc    <= 1'b0;
      o_divided_out_a_oc_oe <= ~div_ff;
      o_divided_out_b_oc    <= 1'b0;
      o_divided_out_b_oc_oe <= ~out_b_sel;
    end
  end

  // avalon slave: one wait cycle, answer on the second edge of a request
  logic        ack_ff;
  logic        wait_ff;
  logic [31:0] rdata_ff;
  wire  logic  req     = i_avs_read | i_avs_write;
  wire  logic  take    = req & ~ack_ff;
  // a write lands on the edge where the master sees waitrequest low, never earlier
  wire  logic  commit  = req & ack_ff;
  wire  logic  hit_ctrl = (i_avs_address == ADDR_CTRL);
  // status fields sit side by side so the divisor reads back whole
  wire  logic [31:0] status_w = {22'h00_0000, out_b, dir_ff, div_ff, cfg.clr, cfg.dir_mode, cfg.divisor};
  wire  logic [31:0] rd_mux =
    hit_ctrl                         ? ctrl_ff :
    (i_avs_address == ADDR_STATUS)   ? status_w :
    (i_avs_address == ADDR_COUNT)    ? {27'h000_0000, cnt_ff} : UNMAPPED_RD;
  assign nxt_ctrl = (commit & i_avs_write & hit_ctrl) ? i_avs_writedata : ctrl_ff;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ack_ff   <= 1'b0;
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0000_0000;
      ctrl_ff  <= CTRL_RST;
    end else begin
      ack_ff   <= take;
      wait_ff  <= ~take;
      ctrl_ff  <= nxt_ctrl;
      if (take & i_avs_read) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  assign o_avs_readdata    = rdata_ff;
  assign o_avs_waitrequest = wait_ff;

  // checks
  a_clear_zeroes: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !cfg.clr |=> (cnt_ff == CNT_RST) && !div_ff)
    else $error("counter not held at zero by clear");
  a_dir_on_b: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    cfg.dir_mode |=> o_div_b_p == $past(dir_ff))
    else $error("b output is not direction in mode 1");
  a_a_divided: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    1'b1 |=> o_div_a_p == $past(div_ff) && o_div_a_n == !$past(div_ff))
    else $error("a output does not follow divider");
  a_count_bound: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    cnt_ff < div_n |=> cnt_ff < $past(div_n))
    else $error("count exceeds divisor");
  a_toggle_wrap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    cfg.clr && a_edge && cnt_wrap |=> $changed(div_ff))
    else $error("divider did not toggle at wrap");
  a_b_pulse_mode: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !cfg.dir_mode ##1 !cfg.dir_mode |-> o_div_b_p == $past(b_div_ff))
    else $error("b output not divided in mode 0");
  a_oc_level: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n) |-> o_divided_out_a_oc_oe == !o_div_a_p && !o_divided_out_a_oc)
    else $error("open collector a disagrees with line driver");
  a_b_oc_level: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n) |-> o_divided_out_b_oc_oe == !o_div_b_p &&
      o_div_b_n == !o_div_b_p && !o_divided_out_b_oc)
    else $error("b open collector or pair disagrees with b line");
  a_dir_from_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    a_rise && !b_edge |=> dir_ff == $past(enc_s.b))
    else $error("direction wrong after a rising a edge");
  a_rdata_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !(i_avs_read && o_avs_waitrequest) |=> $stable(o_avs_readdata))
    else $error("read data moved outside a read");
  a_bus_answer: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("request not answered after one wait cycle");
  a_switch_invert: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !sw_src_reg && $past(i_rst_n) && $past(i_rst_n, 2) |->
      cfg.divisor == ~$past(i_setting_switch_bank_closed[SW_DIV_LSB +: DIV_W], 2))
    else $error("switch polarity wrong");
  c_wrap: cover property (@(posedge i_clk) disable iff (!i_rst_n) a_edge && cnt_wrap && cfg.clr);
  c_dir_mode: cover property (@(posedge i_clk) disable iff (!i_rst_n) cfg.dir_mode && b_edge);
  c_clear: cover property (@(posedge i_clk) disable iff (!i_rst_n) !cfg.clr ##1 cfg.clr);
  c_b_leads: cover property (@(posedge i_clk) disable iff (!i_rst_n) cfg.dir_mode && dir_ff && b_edge);
  c_ctrl_src: cover property (@(posedge i_clk) disable iff (!i_rst_n) sw_src_reg && !o_avs_waitrequest);
endmodule

//--- pulse_divider_pkg.sv
// shared constants and carriers for the encoder pulse divider
package pulse_divider_pkg;

  localparam int unsigned DIV_W      = 5;
  localparam int unsigned SW_W       = 7;
  // switch bank layout: bits 0..4 divisor, bit 5 output type, bit 6 counter clear
  localparam int unsigned SW_DIV_LSB = 0;
  localparam int unsigned SW_MODE    = 5;
  localparam int unsigned SW_CLR     = 6;
  localparam logic [DIV_W-1:0] DIV_MIN = 5'h01;
  localparam logic [DIV_W-1:0] CNT_RST = 5'h00;

  // register map
  localparam logic [3:0]  ADDR_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_STATUS = 4'h4;
  localparam logic [3:0]  ADDR_COUNT  = 4'h8;
  localparam int unsigned CTRL_SRC    = 0;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

  localparam int unsigned CLK_HZ    = 10_000_000;
  localparam int unsigned MAX_OUT_HZ = 100_000;

  typedef struct packed {
    logic [DIV_W-1:0] divisor;
    logic             dir_mode;
    logic             clr;
  } cfg_t;

  typedef struct packed {
    logic a;
    logic b;
  } quad_t;

endpackage

//--- sync2.sv
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/10ps
module sync2 #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // async level in, synchronised out
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else begin
      meta_ff <= i_d;
      q_ff    <= meta_ff;
    end
  end

  assign o_q = q_ff;
endmodule

//--- quad_encoder_model.sv
// incremental encoder model: quadrature pairs, one step every 8 clocks
`timescale 1ns/10ps
module quad_encoder_model
  import pulse_divider_pkg::*;
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // run request: whole periods, direction 1 = b leads
  input  wire logic       i_start,
  input  wire logic       i_dir,
  input  wire logic [7:0] i_periods,
  // encoder lines
  output quad_t           o_q,
  output logic            o_busy
);
  logic [9:0] left_ff;
  logic [2:0] tick_ff;
  logic [1:0] ph_ff;
  // slow steps keep every level well past the two-flop synchroniser
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      left_ff <= 10'h000;
      tick_ff <= 3'h0;
      ph_ff   <= 2'h0;
    end else if (i_start) begin
      left_ff <= {i_periods, 2'b00};
      tick_ff <= 3'h0;
    end else if (left_ff != 10'h000) begin
      tick_ff <= tick_ff + 3'h1;
      if (tick_ff == 3'h7) begin
        ph_ff   <= i_dir ? ph_ff - 2'h1 : ph_ff + 2'h1;
        left_ff <= left_ff - 10'h001;
      end
    end
  end
  assign o_q.a  = ph_ff[1] ^ ph_ff[0];
  assign o_q.b  = ph_ff[1];
  assign o_busy = (left_ff != 10'h000);
endmodule

//--- test_encoder_pulse_divider.sv
// self-checking bench for the encoder pulse divider
`timescale 1ns/10ps
module test_encoder_pulse_divider
  import pulse_divider_pkg::*;
;
  logic        clk, rst_n, start, dir, busy, ap, an, bp, bn, aoc, aoe, boc, boe, rd, we, wait_q, pa_q;
  logic [7:0]  per;
  logic [6:0]  sw;
  logic [3:0]  addr;
  logic [31:0] wd, rdat, q;
  quad_t       enc;
  int          num_errors, n_tests, rises, base;
  logic [4:0]  div_tab [3] = '{5'h01, 5'h0D, 5'h1F};
  logic [7:0]  per_tab [3] = '{8'h04, 8'h0D, 8'h1F};

  quad_encoder_model enc_m (.i_clk(clk), .i_rst_n(rst_n), .i_start(start), .i_dir(dir),
    .i_periods(per), .o_q(enc), .o_busy(busy));
  encoder_pulse_divider DUT (.i_clk(clk), .i_rst_n(rst_n), .i_enc_a(enc.a), .i_enc_b(enc.b),
    .i_setting_switch_bank_closed(sw), .o_div_a_p(ap), .o_div_a_n(an), .o_div_b_p(bp), .o_div_b_n(bn),
    .o_divided_out_a_oc(aoc), .o_divided_out_a_oc_oe(aoe), .o_divided_out_b_oc(boc),
    .o_divided_out_b_oc_oe(boe), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(we),
    .i_avs_writedata(wd), .o_avs_readdata(rdat), .o_avs_waitrequest(wait_q));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    pa_q <= ap;
    if (ap === 1'b1 && pa_q === 1'b0) rises <= rises + 1;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    addr <= a; rd <= !w; we <= w; wd <= d;
    do begin @(posedge clk); end while (wait_q !== 1'b0);
    r = rdat;
    rd <= 1'b0; we <= 1'b0;
    @(posedge clk);
  endtask
  // clear held closed while the new setting settles; logic value is the inverse of closed
  task automatic cfg(input logic [4:0] n, input logic m);
    sw <= {1'b1, ~m, ~n}; // callers keep n within 1 to 31
    repeat (6) @(posedge clk);
    sw[6] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic run(input logic d, input logic [7:0] p);
    base = rises;
    dir <= d; per <= p; start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    do begin @(posedge clk); end while (busy !== 1'b0);
    repeat (8) @(posedge clk);
  endtask
  task automatic test_done();
    if (num_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    test_done();
  end
  initial begin
    rst_n = 1'b0; start = 1'b0; dir = 1'b0; per = 8'h00; sw = 7'h00;
    addr = 4'h0; rd = 1'b0; we = 1'b0; wd = 32'h0000_0000; rises = 0; pa_q = 1'b0;
    num_errors = 0; n_tests = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus(ADDR_CTRL, 1'b0, 32'h0000_0000, q);
    chk("ctrl reset", CTRL_RST, q);
    bus(4'hC, 1'b1, 32'hFFFF_FFFF, q);
    bus(4'hC, 1'b0, 32'h0000_0000, q);
    chk("unmapped", UNMAPPED_RD, q);
    // register source: clear released, type 0, divisor 11
    bus(ADDR_CTRL, 1'b1, 32'h0000_0097, q);
    bus(ADDR_CTRL, 1'b0, 32'h0000_0000, q);
    chk("ctrl readback", 32'h0000_0097, q);
    bus(ADDR_STATUS, 1'b0, 32'h0000_0000, q);
    chk("status from ctrl", {25'h0, 1'b1, 1'b0, 5'h0B}, {25'h0, q[6:0]});
    bus(ADDR_CTRL, 1'b1, CTRL_RST, q);
    for (int i = 0; i < 3; i++) begin
      cfg(div_tab[i], 1'b0);
      bus(ADDR_STATUS, 1'b0, 32'h0000_0000, q);
      chk("status", {25'h0, 1'b1, 1'b0, div_tab[i]}, {25'h0, q[6:0]});
      run(1'b0, per_tab[i]);
      chk("a rises", ((2 * per_tab[i] / div_tab[i]) + 1) / 2, rises - base);
      chk("a pair", {31'h0, ~ap}, {31'h0, an});
      chk("a oc", {30'h0, ~ap, 1'b0}, {30'h0, aoe, aoc});
      chk("b pair", {31'h0, ~bp}, {31'h0, bn});
      chk("b oc", {30'h0, ~bp, 1'b0}, {30'h0, boe, boc});
      chk("b level", (2 * per_tab[i] / div_tab[i]) % 2, {31'h0, bp});
    end
    cfg(5'h01, 1'b1);
    run(1'b0, 8'h04);
    chk("a rises dir", 32'h0000_0004, rises - base);
    chk("b dir a lead", 32'h0000_0006, {28'h0, bp, bn, boe, boc});
    run(1'b1, 8'h04);
    chk("b dir b lead", 32'h0000_0008, {28'h0, bp, bn, boe, boc});
    cfg(5'h03, 1'b0);
    run(1'b0, 8'h01);
    cfg(5'h03, 1'b0);
    run(1'b0, 8'h01);
    chk("cleared count", 32'h0000_0000, {31'h0, ap} + rises - base);
    bus(ADDR_COUNT, 1'b0, 32'h0000_0000, q);
    chk("count reg", 32'h0000_0002, q);
    test_done();
  end
endmodule
